// *** dtfl_top.sv ***
// Drive terminal function logic: input decode, output mapping, AXI4-Lite slave
`timescale 1ns/1ps
module dtfl_top
  import dtfl_pkg::*;
(
  // Clock and reset
  input  wire logic                 i_clk_sys,
  input  wire logic                 i_rst_b,
  // AXI4-Lite write address and data
  input  wire logic                 i_awvalid,
  output logic                      o_awready,
  input  wire logic [7:0]           i_awaddr,
  input  wire logic                 i_wvalid,
  output logic                      o_wready,
  input  wire logic [31:0]          i_wdata,
  input  wire logic [3:0]           i_wstrb,
  // AXI4-Lite write response
  output logic                      o_bvalid,
  input  wire logic                 i_bready,
  output logic [1:0]                o_bresp,
  // AXI4-Lite read
  input  wire logic                 i_arvalid,
  output logic                      o_arready,
  input  wire logic [7:0]           i_araddr,
  output logic                      o_rvalid,
  input  wire logic                 i_rready,
  output logic [31:0]               o_rdata,
  output logic [1:0]                o_rresp,
  // Terminals and core status
  input  wire logic [DTFL_NUM_IN-1:0] i_in_term,
  input  wire logic                 i_run_term_a,
  input  wire logic                 i_run_term_b,
  input  wire logic                 i_motor_stopped,
  input  wire dtfl_status_t         i_status,
  // Decoded commands and outputs
  output dtfl_cmd_t                 o_cmd,
  output logic                      o_forced_stop_alarm,
  output logic [DTFL_NUM_OUT-1:0]   o_out_term
);

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  logic [DTFL_CODE_W-1:0]  in_code_reg [DTFL_NUM_IN];   // Input terminal codes
  logic [DTFL_CODE_W-1:0]  run_a_reg;                   // run_terminal_assign_a
  logic [DTFL_CODE_W-1:0]  run_b_reg;                   // run_terminal_assign_b
  logic [DTFL_OCODE_W-1:0] out_code_reg [DTFL_NUM_OUT]; // Output codes
  logic                    freq1_sense_select_reg;      // 0 normal, 1 inverse
  logic [1:0]              pid_mode_select_reg;         // 0 off, 1 normal, 2 inverse
  logic [7:0]              wr_addr_reg;                 // Latched write address
  logic [31:0]             wr_data_reg;                 // Latched write data
  logic [3:0]              wr_strb_reg;                 // Latched strobes
  logic                    aw_held_reg;                 // Address taken
  logic                    w_held_reg;                  // Data taken
  logic                    alarm_latch_reg;             // Forced-stop alarm
  logic                    stop_pending_reg;            // Stopping under force

  // ---------------------------------------------------------------
  // Input terminal decode
  // ---------------------------------------------------------------
  logic [DTFL_NUM_IN-1:0] hit_cancel, hit_inv, hit_comm, hit_mon, hit_srch;
  logic [DTFL_NUM_IN-1:0] hit_stop, hit_clr, hit_frz;
  logic [DTFL_NUM_IN-1:0] mon_bits;   // Monitor-only terminal levels

  // True when a terminal carries the code and is ON
  function automatic logic in_term_on(input int idx, input logic [6:0] code);
    in_term_on = (in_code_reg[idx] == code) & i_in_term[idx];
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < DTFL_NUM_IN; gi++)
    begin : g_in
      // Each terminal contributes only to the function its code selects
      assign hit_cancel[gi] = in_term_on(gi, DTFL_IN_PID_CANCEL);
      assign hit_inv[gi]    = in_term_on(gi, DTFL_IN_INVERSE);
      assign hit_comm[gi]   = in_code_reg[gi] == DTFL_IN_COMM_PRIO;
      assign hit_mon[gi]    = in_code_reg[gi] == DTFL_IN_MONITOR;
      assign hit_srch[gi]   = in_term_on(gi, DTFL_IN_SPEED_SRCH);
      assign hit_stop[gi]   = in_code_reg[gi] == DTFL_IN_FORCE_STOP;
      assign hit_clr[gi]    = in_term_on(gi, DTFL_IN_PID_CLEAR);
      assign hit_frz[gi]    = in_term_on(gi, DTFL_IN_PID_FREEZE);
      // Monitor inputs are only captured for read-back
      assign mon_bits[gi]   = hit_mon[gi] & i_in_term[gi];
    end
  endgenerate

  // Comm priority ON when any assigned terminal is ON, or none assigned
  logic comm_on;
  assign comm_on = (|(hit_comm & i_in_term)) | ~(|hit_comm);

  // Forced stop requested while any assigned terminal is OFF
  logic stop_req;
  assign stop_req = |(hit_stop & ~i_in_term);

  // Run terminals honour only run codes; anything else is ignored
  logic fwd_on, rev_on;
  assign fwd_on = (run_a_reg == DTFL_IN_FWD & i_run_term_a) |
                  (run_b_reg == DTFL_IN_FWD & i_run_term_b);
  assign rev_on = (run_a_reg == DTFL_IN_REV & i_run_term_a) |
                  (run_b_reg == DTFL_IN_REV & i_run_term_b);

  // ---------------------------------------------------------------
  // Normal/inverse resolution
  // ---------------------------------------------------------------
  logic inv_on, pid_en, pid_act, a1_inv, pid_inv, man_inv;
  assign inv_on  = |hit_inv;
  assign pid_en  = pid_mode_select_reg != DTFL_PID_OFF;
  assign pid_act = pid_en & ~(|hit_cancel);
  assign a1_inv  = freq1_sense_select_reg ^ inv_on;
  assign pid_inv = (pid_mode_select_reg == DTFL_PID_INVERSE) ^ inv_on;
  assign man_inv = freq1_sense_select_reg;

  // Registered command outputs
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_cmd <= '0;
    end
    else
    begin
      o_cmd.analog1_inverse   <= pid_en ? man_inv : a1_inv;
      o_cmd.pid_inverse       <= pid_inv;
      o_cmd.manual_inverse    <= man_inv;
      o_cmd.final_inverse     <= pid_act ? pid_inv : man_inv;
      o_cmd.pid_active        <= pid_act;
      o_cmd.comm_priority_cmd <= comm_on;
      o_cmd.speed_search_cmd  <= |hit_srch;
      o_cmd.forced_stop_req   <= stop_req;
      o_cmd.pid_terms_clear_cmd     <= |hit_clr;
      o_cmd.pid_integral_freeze_cmd <= |hit_frz;
      // Both run directions at once resolve to stop
      o_cmd.forward_run_cmd   <= fwd_on & ~rev_on & ~stop_req;
      o_cmd.reverse_run_cmd   <= rev_on & ~fwd_on & ~stop_req;
    end
  end

  // Forced stop: alarm once the motor reaches standstill
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      stop_pending_reg <= 1'b0;
      alarm_latch_reg  <= 1'b0;
    end
    else
    begin
      // Pending follows the request, so a withdrawn stop never alarms later
      stop_pending_reg <= stop_req;
      // Alarm holds until the stop command returns ON
      if (stop_pending_reg & stop_req & i_motor_stopped)
        alarm_latch_reg <= 1'b1;
      else if (!stop_req)
        alarm_latch_reg <= 1'b0;
    end
  end
  assign o_forced_stop_alarm = alarm_latch_reg;

  // ---------------------------------------------------------------
  // Output terminal mapping
  // ---------------------------------------------------------------
  // Select one status bit from a code below 1000
  function automatic logic status_pick(input logic [10:0] code, input dtfl_status_t s);
    case (code)
      11'd0:   status_pick = s.running;
      11'd1:   status_pick = s.freq_arrive;
      11'd2:   status_pick = s.freq_detect;
      11'd3:   status_pick = s.undervolt;
      11'd4:   status_pick = s.torque_brake;
      11'd5:   status_pick = s.out_limit;
      11'd6:   status_pick = s.auto_restart;
      11'd7:   status_pick = s.ovl_warn;
      11'd10:  status_pick = s.ready;
      11'd21:  status_pick = s.freq_arrive2;
      11'd22:  status_pick = s.out_limit_dly;
      11'd26:  status_pick = s.auto_reset;
      11'd28:  status_pick = s.heat_warn;
      11'd30:  status_pick = s.life_alarm;
      11'd33:  status_pick = s.ref_loss;
      11'd35:  status_pick = s.out_on;
      11'd36:  status_pick = s.ovl_prevent;
      11'd37:  status_pick = s.cur_detect;
      11'd38:  status_pick = s.cur_detect2;
      11'd42:  status_pick = s.pid_alarm;
      11'd49:  status_pick = s.motor2;
      11'd57:  status_pick = s.brake_output;
      DTFL_OUT_ALARM: status_pick = s.any_alarm_output;
      default: status_pick = 1'b0;   // Reserved 80-82 and unused codes
    endcase
  endfunction

  generate
    for (gi = 0; gi < DTFL_NUM_OUT; gi++)
    begin : g_out
      logic neg;          // Active-OFF polarity flag
      logic [10:0] base;  // Code with polarity offset removed
      assign neg  = out_code_reg[gi] >= DTFL_OUT_NEG_OFS;
      assign base = neg ? out_code_reg[gi] - DTFL_OUT_NEG_OFS : out_code_reg[gi];
      // Level recomputed every cycle; relay energizes when level is high
      always_ff @(posedge i_clk_sys or negedge i_rst_b)
      begin
        if (!i_rst_b)
          o_out_term[gi] <= 1'b0;
        else
          o_out_term[gi] <= status_pick(base, i_status) ^ neg;
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // AXI4-Lite write path
  // ---------------------------------------------------------------
  logic wr_go;  // Both halves present, response slot free
  assign wr_go = aw_held_reg & w_held_reg & ~o_bvalid;

  // Accept address and data independently, one write at a time
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      wr_addr_reg <= '0;
      wr_data_reg <= '0;
      wr_strb_reg <= '0;
      o_awready   <= 1'b1;
      o_wready    <= 1'b1;
    end
    else
    begin
      if (i_awvalid & o_awready)
      begin
        aw_held_reg <= 1'b1;
        wr_addr_reg <= i_awaddr;
        o_awready   <= 1'b0;
      end
      if (i_wvalid & o_wready)
      begin
        w_held_reg  <= 1'b1;
        wr_data_reg <= i_wdata;
        wr_strb_reg <= i_wstrb;
        o_wready    <= 1'b0;
      end
      if (o_bvalid & i_bready)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        o_awready   <= 1'b1;
        o_wready    <= 1'b1;
      end
    end
  end

  // Write response
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_bvalid <= 1'b0;
      o_bresp  <= DTFL_RESP_OKAY;
    end
    else if (wr_go)
    begin
      o_bvalid <= 1'b1;
      o_bresp  <= (wr_addr_reg[7:2] <= DTFL_OFS_SENSE[7:2]) ? DTFL_RESP_OKAY : DTFL_RESP_SLVERR;
    end
    else if (i_bready)
      o_bvalid <= 1'b0;
  end

  // Register update on a completed write, byte lanes honoured
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      for (int k = 0; k < DTFL_NUM_IN; k++)
        in_code_reg[k] <= DTFL_IN_NONE;
      run_a_reg <= DTFL_RST_RUN_A;
      run_b_reg <= DTFL_RST_RUN_B;
      out_code_reg[0] <= DTFL_RST_OCODE;
      out_code_reg[1] <= DTFL_RST_OCODE;
      out_code_reg[DTFL_RELAY_IDX] <= DTFL_RST_RCODE;
      freq1_sense_select_reg <= 1'b0;
      pid_mode_select_reg    <= DTFL_PID_OFF;
    end
    else if (wr_go)
    begin
      unique case ({wr_addr_reg[7:2], 2'b00})
        DTFL_OFS_IN_ASSIGN0:
        begin
          for (int k = 0; k < 4; k++)
            if (wr_strb_reg[k]) in_code_reg[k] <= wr_data_reg[8*k +: 7];
        end
        DTFL_OFS_IN_ASSIGN1:
          if (wr_strb_reg[0]) in_code_reg[4] <= wr_data_reg[6:0];
        DTFL_OFS_RUN_ASSIGN:
        begin
          if (wr_strb_reg[0]) run_a_reg <= wr_data_reg[6:0];
          if (wr_strb_reg[1]) run_b_reg <= wr_data_reg[14:8];
        end
        DTFL_OFS_OUT_ASSIGN:
        begin
          if (&wr_strb_reg[1:0]) out_code_reg[0] <= wr_data_reg[10:0];
          if (&wr_strb_reg[3:2]) out_code_reg[1] <= wr_data_reg[26:16];
        end
        DTFL_OFS_RELAY:
          if (&wr_strb_reg[1:0]) out_code_reg[DTFL_RELAY_IDX] <= wr_data_reg[10:0];
        DTFL_OFS_SENSE:
          if (wr_strb_reg[0])
          begin
            freq1_sense_select_reg <= wr_data_reg[0];
            pid_mode_select_reg    <= wr_data_reg[5:4];
          end
        default: ;   // Unmapped: answered with an error, nothing stored
      endcase
    end
  end

  // ---------------------------------------------------------------
  // AXI4-Lite read path
  // ---------------------------------------------------------------
  logic [31:0] rd_word;  // Data for the requested address
  logic        rd_ok;    // Address is mapped
  always_comb
  begin
    rd_word = '0;
    rd_ok   = 1'b1;
    unique case ({i_araddr[7:2], 2'b00})
      DTFL_OFS_IN_ASSIGN0: rd_word = {1'b0, in_code_reg[3], 1'b0, in_code_reg[2],
                                      1'b0, in_code_reg[1], 1'b0, in_code_reg[0]};
      DTFL_OFS_IN_ASSIGN1: rd_word = {25'h0, in_code_reg[4]};
      DTFL_OFS_RUN_ASSIGN: rd_word = {17'h0, run_b_reg, 1'b0, run_a_reg};
      DTFL_OFS_OUT_ASSIGN: rd_word = {5'h0, out_code_reg[1], 5'h0, out_code_reg[0]};
      DTFL_OFS_RELAY:      rd_word = {21'h0, out_code_reg[DTFL_RELAY_IDX]};
      DTFL_OFS_SENSE:      rd_word = {26'h0, pid_mode_select_reg, 3'h0, freq1_sense_select_reg};
      DTFL_OFS_STATUS:     rd_word = {16'h0, o_out_term, alarm_latch_reg, o_cmd};
      DTFL_OFS_MONITOR:    rd_word = {27'h0, mon_bits};
      default:             rd_ok   = 1'b0;
    endcase
  end

  // One read at a time; answer one cycle after address is taken
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      o_arready <= 1'b1;
      o_rvalid  <= 1'b0;
      o_rdata   <= '0;
      o_rresp   <= DTFL_RESP_OKAY;
    end
    else if (i_arvalid & o_arready)
    begin
      o_arready <= 1'b0;
      o_rvalid  <= 1'b1;
      o_rdata   <= rd_word;
      o_rresp   <= rd_ok ? DTFL_RESP_OKAY : DTFL_RESP_SLVERR;
    end
    else if (o_rvalid & i_rready)
    begin
      o_rvalid  <= 1'b0;
      o_arready <= 1'b1;
    end
  end

endmodule

// *** dtfl_pkg.sv ***
// Package of constants and types for the drive terminal function logic
package dtfl_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] DTFL_OFS_IN_ASSIGN0 = 8'h00;  // Input terminals 0..3 codes
  localparam logic [7:0] DTFL_OFS_IN_ASSIGN1 = 8'h04;  // Input terminal 4 code
  localparam logic [7:0] DTFL_OFS_RUN_ASSIGN = 8'h08;  // Run terminal assignments
  localparam logic [7:0] DTFL_OFS_OUT_ASSIGN = 8'h0C;  // Output 0 and 1 codes
  localparam logic [7:0] DTFL_OFS_RELAY      = 8'h10;  // Relay code
  localparam logic [7:0] DTFL_OFS_SENSE      = 8'h14;  // Sense and PID selections
  localparam logic [7:0] DTFL_OFS_STATUS     = 8'h18;  // Command status read back
  localparam logic [7:0] DTFL_OFS_MONITOR    = 8'h1C;  // Universal monitor inputs

  // ---------------------------------------------------------------
  // Sizes and field positions
  // ---------------------------------------------------------------
  localparam int DTFL_NUM_IN  = 5;   // General input terminals
  localparam int DTFL_NUM_OUT = 3;   // Two transistor and one relay output
  localparam int DTFL_RELAY_IDX = 2; // Index of relay output
  localparam int DTFL_CODE_W  = 7;   // Input function code width
  localparam int DTFL_OCODE_W = 11;  // Output function code width

  // ---------------------------------------------------------------
  // Input function codes
  // ---------------------------------------------------------------
  localparam logic [6:0] DTFL_IN_PID_CANCEL = 7'h14; // 20
  localparam logic [6:0] DTFL_IN_INVERSE    = 7'h15; // 21
  localparam logic [6:0] DTFL_IN_COMM_PRIO  = 7'h18; // 24
  localparam logic [6:0] DTFL_IN_MONITOR    = 7'h19; // 25
  localparam logic [6:0] DTFL_IN_SPEED_SRCH = 7'h1A; // 26
  localparam logic [6:0] DTFL_IN_FORCE_STOP = 7'h1E; // 30
  localparam logic [6:0] DTFL_IN_PID_CLEAR  = 7'h21; // 33
  localparam logic [6:0] DTFL_IN_PID_FREEZE = 7'h22; // 34
  localparam logic [6:0] DTFL_IN_FWD        = 7'h62; // 98
  localparam logic [6:0] DTFL_IN_REV        = 7'h63; // 99
  localparam logic [6:0] DTFL_IN_NONE       = 7'h7F; // Unassigned terminal

  // ---------------------------------------------------------------
  // Output function codes
  // ---------------------------------------------------------------
  localparam logic [10:0] DTFL_OUT_NEG_OFS = 11'h3E8; // 1000 adds active-OFF
  localparam logic [10:0] DTFL_OUT_ALARM   = 11'h063; // 99
  localparam logic [10:0] DTFL_OUT_RESV_LO = 11'h050; // 80
  localparam logic [10:0] DTFL_OUT_RESV_HI = 11'h052; // 82

  // ---------------------------------------------------------------
  // Selections and reset values
  // ---------------------------------------------------------------
  localparam logic [1:0] DTFL_PID_OFF     = 2'h0;
  localparam logic [1:0] DTFL_PID_NORMAL  = 2'h1;
  localparam logic [1:0] DTFL_PID_INVERSE = 2'h2;
  localparam logic [6:0]  DTFL_RST_RUN_A  = 7'h62;   // Forward run
  localparam logic [6:0]  DTFL_RST_RUN_B  = 7'h63;   // Reverse run
  localparam logic [10:0] DTFL_RST_OCODE  = 11'h000; // Running, active-ON
  localparam logic [10:0] DTFL_RST_RCODE  = 11'h063; // Alarm, active-ON
  localparam logic [1:0]  DTFL_RESP_OKAY   = 2'h0;
  localparam logic [1:0]  DTFL_RESP_SLVERR = 2'h2;

  // Status inputs from the drive core, one bit per output function
  typedef struct packed {
    logic running;       // 0
    logic freq_arrive;   // 1
    logic freq_detect;   // 2
    logic undervolt;     // 3
    logic torque_brake;  // 4
    logic out_limit;     // 5
    logic auto_restart;  // 6
    logic ovl_warn;      // 7
    logic ready;         // 10
    logic freq_arrive2;  // 21
    logic out_limit_dly; // 22
    logic auto_reset;    // 26
    logic heat_warn;     // 28
    logic life_alarm;    // 30
    logic ref_loss;      // 33
    logic out_on;        // 35
    logic ovl_prevent;   // 36
    logic cur_detect;    // 37
    logic cur_detect2;   // 38
    logic pid_alarm;     // 42
    logic motor2;        // 49
    logic brake_output;  // 57
    logic any_alarm_output; // 99
  } dtfl_status_t;

  // Decoded commands to the drive core
  typedef struct packed {
    logic analog1_inverse;   // Sense for first-command analog sources
    logic pid_inverse;       // Sense for PID controller output
    logic manual_inverse;    // Sense for manual frequency under PID mode
    logic final_inverse;     // Sense chosen by PID cancel
    logic pid_active;        // PID control in use
    logic comm_priority_cmd;
    logic speed_search_cmd;
    logic forced_stop_req;   // Decelerate by forced-stop time
    logic pid_terms_clear_cmd;
    logic pid_integral_freeze_cmd;
    logic forward_run_cmd;
    logic reverse_run_cmd;
  } dtfl_cmd_t;

endpackage

// *** dtfl_chk.sv ***
// Checker of bus handshakes and decoded command relations
`timescale 1ns/1ps
module dtfl_chk
  import dtfl_pkg::*;
(
  // Clock and reset
  input wire logic        i_clk_sys, i_rst_b,
  // Register bus
  input wire logic        i_awvalid, o_awready, i_wvalid, o_wready, o_bvalid, i_bready,
  input wire logic        i_arvalid, o_arready, o_rvalid, i_rready,
  input wire logic [1:0]  o_bresp,
  input wire logic [31:0] o_rdata,
  // Terminals and commands
  input wire logic        i_motor_stopped, o_forced_stop_alarm,
  input wire dtfl_cmd_t   o_cmd
);
  default clocking @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_b);
  AST_B_LAT: assert property (i_awvalid && o_awready && i_wvalid && o_wready |-> ##2 o_bvalid) else $error("late bvalid");
  AST_B_HOLD: assert property (o_bvalid && !i_bready |=> o_bvalid && $stable(o_bresp)) else $error("bvalid dropped");
  AST_B_BLOCK: assert property (o_bvalid |-> !o_awready && !o_wready) else $error("write taken early");
  AST_R_LAT: assert property (i_arvalid && o_arready |=> o_rvalid && !o_arready) else $error("late rvalid");
  AST_R_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata)) else $error("rvalid dropped");
  AST_RUN: assert property (o_cmd.forward_run_cmd |-> !o_cmd.reverse_run_cmd && !o_cmd.forced_stop_req)
    else $error("bad run command");
  AST_FINAL: assert property (o_cmd.final_inverse ==
    (o_cmd.pid_active ? o_cmd.pid_inverse : o_cmd.manual_inverse)) else $error("bad final sense");
  AST_ALARM: assert property ($rose(o_forced_stop_alarm) |->
    $past(i_motor_stopped) && $past(o_cmd.forced_stop_req)) else $error("alarm without stop");
endmodule
bind dtfl_top dtfl_chk u_chk (.*);

// *** dtfl_equip.sv ***
// Outside equipment model: drives terminal levels, masks outputs after power-on
`timescale 1ns/1ps
module dtfl_equip #(
  parameter int MASK_CYC = 16  // Settling mask, shortened
) (
  // Clock, reset and requests
  input  wire logic       i_clk_sys, i_rst_b,
  input  wire logic [6:0] i_drive,    // {run b, run a, general}
  input  wire logic [2:0] i_out_term,
  // Terminal levels and trusted outputs
  output logic      [4:0] o_in_term,
  output logic            o_run_a, o_run_b,
  output logic      [2:0] o_seen
);
  int cnt;  // Cycles since power-on, saturating at MASK_CYC
  // Levels change only just after an edge
  assign {o_run_b, o_run_a, o_in_term} = i_drive;
  // Mask counter
  always_ff @(posedge i_clk_sys or negedge i_rst_b)
    if (!i_rst_b) cnt <= 0;
    else if (cnt < MASK_CYC) cnt <= cnt + 1;
  assign o_seen = (cnt < MASK_CYC) ? 3'h0 : i_out_term;
endmodule

// *** test_drive_terminal_function_logic.sv ***
// Bench: drives terminals and registers, compares with a behavioural model
`timescale 1ns/1ps
module test_drive_terminal_function_logic
  import dtfl_pkg::*;
;
  logic i_clk_sys = 0, i_rst_b = 0, i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0, i_rready = 0;
  logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_forced_stop_alarm, i_run_term_a, i_run_term_b;
  logic [7:0] i_awaddr = 0, i_araddr = 0;
  logic [31:0] i_wdata = 0, o_rdata, d;
  logic [3:0] i_wstrb = 4'hF;
  logic [1:0] o_bresp, o_rresp, r;
  logic i_motor_stopped = 0;
  logic [4:0] i_in_term;
  logic [2:0] o_out_term, seen;  // seen: outputs after the settling mask
  bit slow = 0;  // Late ready on the answer channels
  logic [6:0] lv = 0;  // Requested terminal levels
  dtfl_status_t i_status = '0;
  dtfl_cmd_t o_cmd;
  int bad_count, checks_done, cyc, sense, mode, ra, rb, c, tc[5], oc[3];
  int ct[23] = '{0, 1, 2, 3, 4, 5, 6, 7, 10, 21, 22, 26, 28, 30, 33, 35, 36, 37, 38, 42, 49, 57, 99};
  logic [31:0] rv[6] = '{32'h7F7F7F7F, 32'h7F, 32'h6362, 32'h0, 32'h63, 32'h0};
  dtfl_top DUT (.*);
  dtfl_equip u_eq (.i_clk_sys, .i_rst_b, .i_drive(lv), .i_out_term(o_out_term), .o_in_term(i_in_term),
    .o_run_a(i_run_term_a), .o_run_b(i_run_term_b), .o_seen(seen));
  always #2.5 i_clk_sys = ~i_clk_sys;
  // Hang guard
  always @(posedge i_clk_sys)
    if (++cyc == 20000)
    begin
      bad_count++;
      results();
    end
  task automatic results();
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic cmp(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, e, g);
    end
  endtask
  // Bus write: both channels offered together, each dropped once taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    logic t;
    @(posedge i_clk_sys);
    {i_awaddr, i_wdata, i_awvalid, i_wvalid, i_bready} <= {a, v, 2'h3, !slow};
    do
    begin
      @(posedge i_clk_sys);
      t = (i_awvalid && !o_awready) || (i_wvalid && !o_wready);
      if (o_awready) i_awvalid <= 0;
      if (o_wready) i_wvalid <= 0;
    end while (t);
    if (slow) repeat (2) @(posedge i_clk_sys);
    i_bready <= 1;
    do @(posedge i_clk_sys); while (!o_bvalid);
    r = o_bresp;
    i_bready <= 0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    {i_araddr, i_arvalid, i_rready} <= {a, 1'b1, !slow};
    do @(posedge i_clk_sys); while (!o_arready);
    i_arvalid <= 0;
    if (slow) repeat (2) @(posedge i_clk_sys);
    i_rready <= 1;
    do @(posedge i_clk_sys); while (!o_rvalid);
    {d, r} = {o_rdata, o_rresp};
    i_rready <= 0;
  endtask
  // Behavioural model of the decoded commands
  function automatic logic [11:0] exp_cmd();
    logic cn, iv, ca, cm, ss, so, cl, fz, pa, pi, fw, rs;
    {cn, iv, ca, cm, ss, so, cl, fz} = 8'h00;
    foreach (tc[i])
    begin
      cn |= tc[i] == 20 && lv[i];
      iv |= tc[i] == 21 && lv[i];
      ca |= tc[i] == 24;
      cm |= tc[i] == 24 && lv[i];
      ss |= tc[i] == 26 && lv[i];
      so |= tc[i] == 30 && !lv[i];
      cl |= tc[i] == 33 && lv[i];
      fz |= tc[i] == 34 && lv[i];
    end
    pa = mode != 0 && !cn;
    pi = (mode == 2) ^ iv;
    fw = (ra == 98 && lv[5]) || (rb == 98 && lv[6]);
    rs = (ra == 99 && lv[5]) || (rb == 99 && lv[6]);
    return {mode != 0 ? sense[0] : sense[0] ^ iv, pi, sense[0], pa ? pi : sense[0], pa, !ca || cm, ss, so, cl, fz,
      fw && !rs && !so, rs && !fw && !so};
  endfunction
  // Behavioural model of the output terminals
  function automatic logic [2:0] exp_out();
    logic [2:0] o;
    foreach (oc[j])
    begin
      o[j] = oc[j] >= 1000;
      foreach (ct[k])
        if (ct[k] == oc[j] % 1000) o[j] ^= i_status[22 - k];
    end
    return o;
  endfunction
  task automatic chk_all();
    repeat (2) @(posedge i_clk_sys);
    cmp("command", exp_cmd(), o_cmd);
    cmp("terminals", exp_out(), o_out_term);
    cmp("trusted terminals", exp_out(), seen);
  endtask
  task automatic cfg();
    wr(8'h00, {tc[3][7:0], tc[2][7:0], tc[1][7:0], tc[0][7:0]});
    wr(8'h04, 32'(tc[4]));
    wr(8'h08, 32'(rb << 8 | ra));
    wr(8'h14, 32'(mode << 4 | sense));
    wr(8'h0C, 32'(oc[1] << 16 | oc[0]));
    wr(8'h10, 32'(oc[2]));
  endtask
  initial
  begin
    void'($urandom(32'h58968CC4));
    ra = 98;
    rb = 99;
    oc = '{0, 0, 99};
    repeat (6) @(posedge i_clk_sys);
    i_rst_b <= 1;
    foreach (rv[i])
    begin
      rd(8'(4 * i));
      cmp("reset value", rv[i], d);
    end
    slow = 1;
    rd(8'h20);
    cmp("unmapped read data", 32'h0, d);
    cmp("unmapped read response", 32'(DTFL_RESP_SLVERR), 32'(r));
    wr(8'h18, 32'hFFFFFFFF);
    cmp("unmapped write", 32'(DTFL_RESP_SLVERR), 32'(r));
    slow = 0;
    for (int m = 0; m < 12; m++)
    begin
      c = m / 6;
      if (c)
        tc = '{21, 98, 26, 33, 34};
      else
        tc = '{21, 20, 24, 30, 25};
      {ra, rb, sense, mode} = {c ? 99 : 98, c ? 98 : 99, m % 2, m / 2 % 3};
      cfg();
      repeat (8)
      begin
        @(posedge i_clk_sys);
        {lv, i_status} <= {7'($urandom), 23'($urandom)};
        chk_all();
        rd(8'h1C);
        cmp("monitor", 32'(lv[4] && c == 0) << 4, d);
      end
    end
    for (int k = 0; k < 26; k++)
    begin
      c = k < 23 ? ct[k] : 57 + k;
      oc = '{c, c + 1000, k % 2 ? c : c + 1000};
      cfg();
      @(posedge i_clk_sys);
      i_status <= 23'($urandom);
      chk_all();
    end
    tc = '{21, 20, 24, 30, 25};
    cfg();
    @(posedge i_clk_sys);
    lv <= 7'h00;
    repeat (4) @(posedge i_clk_sys);
    cmp("alarm", 0, o_forced_stop_alarm);
    i_motor_stopped <= 1;
    repeat (4) @(posedge i_clk_sys);
    cmp("alarm", 1, o_forced_stop_alarm);
    {lv, i_motor_stopped} <= 8'h10;
    repeat (4) @(posedge i_clk_sys);
    cmp("alarm", 0, o_forced_stop_alarm);
    results();
  end
endmodule
